// ==== design/pmsi_clkdiv.sv ====
/*
 * Clock divider toggling a level every half period of system cycles.
 * Assumes the half period input is at least one; it may change at any time.
 */
`timescale 1ns/1ps
module pmsi_clkdiv (
  // Clock, reset, enable.
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Half period in system cycles.
  input wire logic [5:0] i_half,
  // Divided level and its edge pulses.
  output logic o_clk,
  output logic o_rise,
  output logic o_fall
);
  import pmsi_pkg::*;

  pmsi_div_t q;
  pmsi_div_t d;

  always_comb begin
    d = q;
    d.rise = 1'b0;
    d.fall = 1'b0;
    // A compare rather than equality survives a shorter half period.
    if (q.cnt + 6'h01 >= i_half) begin
      d.cnt = 6'h00;
      d.lvl = ~q.lvl;
      d.rise = ~q.lvl;
      d.fall = q.lvl;
    end else begin
      d.cnt = q.cnt + 6'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_clk = q.lvl;
  assign o_rise = q.rise;
  assign o_fall = q.fall;
endmodule

// ==== design/pmsi_fifo2.sv ====
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock; ready on the fill side is registered.
 */
`timescale 1ns/1ps
module pmsi_fifo2 #(
  parameter int W = 8
) (
  // Clock, reset, enable.
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Fill side.
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side.
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  import pmsi_pkg::*;

  logic [W-1:0] mem [2];
  pmsi_fifo_t q;
  pmsi_fifo_t d;
  logic push;
  logic pop;

  assign push = i_valid & q.rdy;
  assign pop = i_ready & (q.cnt != 2'h0);

  always_comb begin
    d = q;
    d.wp = q.wp ^ push;
    d.rp = q.rp ^ pop;
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    d.rdy = d.cnt != 2'h2;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      q <= '{rdy: 1'b1, default: '0};
    end else if (i_ce) begin
      q <= d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_ce && push) begin
      mem[q.wp] <= i_data;
    end
  end

  assign o_ready = q.rdy;
  assign o_valid = q.cnt != 2'h0;
  assign o_data = mem[q.rp];
endmodule

// ==== design/pmsi_mac_if.sv ====
/*
 * MAC-side data interface of a single-pair 10 Mb/s PHY: MII, RGMII-style
 * nibble repeater mode, RMII slave and master, low-power 5 MHz master,
 * clock output selection and line-level ability resolution.
 * Assumes the line side delivers and accepts bytes on the system clock and
 * that MAC pins, straps, reference and recovered clocks are asynchronous.
 */
// The placing of the registers and the Wishbone register port were decided locally.

// Behaviour
// - MII moves 4-bit nibbles qualified by enable/valid.
// - Carrier sense high while receiving or transmitting.
// - Collision on simultaneous activity in half duplex.
// - RMII moves two bits per reference clock.
// - RMII transmit and receive dibit paths independent.
// - RMII master drives its own interface clock.
// - RMII slave samples on reference input edges.
// - RMII master data timed by output clock.
// - Optional plain data valid replaces combined pin.
// - Low-power master drives 5 MHz interface clock.
// - Strap switches combined pin to data valid.
// - RGMII repeater mode runs interface at 2.5 MHz.
// - Resolve highest level both ends advertise.
// - Advertise both levels by default.
// - Strap or register restricts to low level.
// - One clock output, source selected by register.
`timescale 1ns/1ps
module pmsi_mac_if (
  // Clock, reset, enable.
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Reference, recovered clock and straps (asynchronous).
  input wire logic i_ref_clock_input_pin,
  input wire logic i_rec_clk,
  input wire logic i_strap_rxdv,
  input wire logic i_strap_low_amp,
  // MAC transmit pins (asynchronous).
  input wire logic i_tx_en,
  input wire logic [3:0] i_txd,
  // MAC receive pins and clocks.
  output logic [3:0] o_rxd,
  output logic o_rx_dv,
  output logic o_crs,
  output logic o_col,
  output logic o_crs_dv,
  output logic o_mac_clk,
  output logic o_clk_out,
  // Line side receive bytes.
  input wire logic i_line_rx_valid,
  input wire logic [7:0] i_line_rx_data,
  output logic o_line_rx_ready,
  input wire logic i_line_crs,
  // Line side transmit bytes.
  output logic o_line_tx_valid,
  output logic [7:0] o_line_tx_data,
  output logic o_line_tx_frame,
  // Line ability negotiation.
  input wire logic i_lp_valid,
  input wire pmsi_pkg::pmsi_abil_t i_lp_abil,
  output logic o_adv_hi,
  output logic o_adv_lo,
  output logic [1:0] o_resolved
);
  import pmsi_pkg::*;

  //////////////////////////////////////////////////////////////////////////

  function automatic logic f_nib(input logic [2:0] mode);
    return (mode == MODE_MII) || (mode == MODE_RGMII);
  endfunction

  function automatic logic [3:0] f_sym(input logic nib, input logic [7:0] b);
    return nib ? b[3:0] : {2'h0, b[1:0]};
  endfunction

  function automatic logic [7:0] f_rest(input logic nib, input logic [7:0] b);
    return nib ? {4'h0, b[7:4]} : {2'h0, b[7:2]};
  endfunction

  //////////////////////////////////////////////////////////////////////////

  pmsi_state_t q;
  pmsi_state_t d;
  pmsi_stat_t stat;
  pmsi_abil_t adv;
  logic [5:0] half;
  logic div_clk;
  logic div_rise;
  logic div_fall;
  logic free_clk;
  logic nib;
  logic slave;
  logic ref_rise;
  logic tx_tick;
  logic rx_tick;
  logic f_valid;
  logic [7:0] f_data;
  logic pop;
  logic rxdv_sel;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic wr_ctrl;

  assign nib = f_nib(q.ctrl.mode);
  assign slave = q.ctrl.mode == MODE_RMII_S;
  assign ref_rise = q.ref_s2 & ~q.ref_d;
  // Slave timing follows the reference input, master timing the own clock.
  assign tx_tick = slave ? ref_rise : div_rise;
  assign rx_tick = slave ? ref_rise : div_fall;
  assign rxdv_sel = q.ctrl.rxdv_sel | q.strap_rxdv;
  // The system clock cannot make 50 MHz exactly; the nearest rate is used.
  always_comb begin
    case (q.ctrl.mode)
      MODE_RMII_M: half = HALF_RM;
      MODE_LP5: half = HALF_LP;
      MODE_RGMII: half = HALF_MII;
      default: half = HALF_MII;
    endcase
  end
  assign adv.lo = 1'b1;
  assign adv.hi = ~(q.ctrl.low_amp | q.strap_lo);
  // A write lands on the edge at which the master sees ack high.
  assign wr_ctrl = i_wb_cyc & i_wb_stb & i_wb_we & q.wb_ack & i_wb_sel[0]
                   & (i_wb_adr == ADR_CTRL);

  always_comb begin
    stat.col = q.pins.col;
    stat.rx_act = q.rx_st == RX_SHIFT;
    stat.tx_act = q.line_tx_frm;
    stat.res = q.res;
    stat.lp = q.lp;
    stat.adv = adv;
    stat.strap_lo = q.strap_lo;
    stat.strap_rxdv = q.strap_rxdv;
  end

  //////////////////////////////////////////////////////////////////////////

  pmsi_clkdiv u_mac_div (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_half(half),
    .o_clk(div_clk),
    .o_rise(div_rise),
    .o_fall(div_fall)
  );

  // The free-running clock keeps toggling whatever the interface mode.
  pmsi_clkdiv u_free_div (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_half(HALF_FREE),
    .o_clk(free_clk),
    .o_rise(),
    .o_fall()
  );

  // A stalled interface back-pressures the line instead of dropping bytes.
  pmsi_fifo2 #(.W(8)) u_rx_buf (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_valid(i_line_rx_valid),
    .i_data(i_line_rx_data),
    .o_ready(o_line_rx_ready),
    .o_valid(f_valid),
    .o_data(f_data),
    .i_ready(pop)
  );

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    d = q;
    pop = 1'b0;
    sh = q.tx_sh;
    cnt = q.tx_bits;
    // Two-flop synchronisers for every asynchronous input.
    d.tx_s1 = '{en: i_tx_en, d: i_txd};
    d.tx_s2 = q.tx_s1;
    d.ref_s1 = i_ref_clock_input_pin;
    d.ref_s2 = q.ref_s1;
    d.ref_d = q.ref_s2;
    d.rec_s1 = i_rec_clk;
    d.rec_s2 = q.rec_s1;
    d.stp_s1 = {i_strap_low_amp, i_strap_rxdv};
    d.stp_s2 = q.stp_s1;
    // Straps are caught once, after the synchronisers have settled.
    if (q.stp_wait != STRAP_WAIT) begin
      d.stp_wait = q.stp_wait + 2'h1;
      if (d.stp_wait == STRAP_WAIT) begin
        d.strap_rxdv = q.stp_s2[0];
        d.strap_lo = q.stp_s2[1];
      end
    end

    // Transmit: gather symbols LSB first into bytes for the line.
    d.line_tx_vld = 1'b0;
    if (tx_tick) begin
      d.line_tx_frm = q.tx_s2.en;
      if (q.tx_s2.en) begin
        if (nib) begin
          sh = {q.tx_s2.d, q.tx_sh[7:4]};
          cnt = q.tx_bits + NIB_W;
        end else begin
          sh = {q.tx_s2.d[1:0], q.tx_sh[7:2]};
          cnt = q.tx_bits + DIB_W;
        end
        if (cnt >= BYTE_BITS) begin
          d.line_tx_vld = 1'b1;
          d.line_tx_dat = sh;
          d.txcnt = q.txcnt + 16'h0001;
          cnt = 4'h0;
        end
        d.tx_sh = sh;
        d.tx_bits = cnt;
      end else begin
        // A partial byte at the end of a frame is discarded.
        d.tx_bits = 4'h0;
      end
    end

    // Receive: serialise buffered bytes, independent of transmit.
    case (q.rx_st)
      RX_IDLE: begin
        if (rx_tick && f_valid) begin
          pop = 1'b1;
          d.pins.d = f_sym(nib, f_data);
          d.rx_sh = f_rest(nib, f_data);
          d.rx_left = nib ? NIB_LAST : DIB_LAST;
          d.pins.dv = 1'b1;
          d.rx_st = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (rx_tick) begin
          if (q.rx_left != 3'h0) begin
            d.pins.d = f_sym(nib, q.rx_sh);
            d.rx_sh = f_rest(nib, q.rx_sh);
            d.rx_left = q.rx_left - 3'h1;
          end else if (f_valid) begin
            pop = 1'b1;
            d.pins.d = f_sym(nib, f_data);
            d.rx_sh = f_rest(nib, f_data);
            d.rx_left = nib ? NIB_LAST : DIB_LAST;
          end else begin
            d.pins.d = 4'h0;
            d.pins.dv = 1'b0;
            d.rx_st = RX_IDLE;
          end
        end
      end
      default: begin
        d.pins.dv = 1'b0;
        d.rx_st = RX_IDLE;
      end
    endcase
    // Pin flags follow the next data valid, so they change with the data.
    d.pins.crs = d.pins.dv | i_line_crs | q.tx_s2.en;
    d.pins.col = q.ctrl.hdx & q.tx_s2.en & (d.pins.dv | i_line_crs);
    d.pins.crs_dv = rxdv_sel ? d.pins.dv : (d.pins.dv | i_line_crs);

    // Interface clock and selectable clock output.
    // In slave mode the interface clock is the reference, three flops late.
    d.mac_clk = slave ? q.ref_s2 : div_clk;
    case (q.ctrl.cko)
      CKO_REF: d.clk_out = q.ref_s2;
      CKO_FREE: d.clk_out = free_clk;
      CKO_REC: d.clk_out = q.rec_s2;
      default: d.clk_out = d.mac_clk;
    endcase

    // Advertised levels are registered so every top output is a flop.
    d.adv = adv;
    // Ability resolution picks the highest common level.
    if (i_lp_valid) begin
      d.lp = i_lp_abil;
    end
    if (adv.hi && d.lp.hi) begin
      d.res = RES_HI;
    end else if (adv.lo && d.lp.lo) begin
      d.res = RES_LO;
    end else begin
      d.res = RES_NONE;
    end

    // Wishbone: answer one cycle after the strobe; write on the ack edge.
    // Unmapped offsets read as zero instead of stalling the master.
    d.wb_ack = i_wb_cyc & i_wb_stb & ~q.wb_ack;
    if (d.wb_ack) begin
      case (i_wb_adr)
        ADR_CTRL: d.wb_dat = 32'(q.ctrl);
        ADR_STAT: d.wb_dat = 32'(stat);
        ADR_TXCNT: d.wb_dat = 32'(q.txcnt);
        default: d.wb_dat = 32'h00000000;
      endcase
    end
    if (wr_ctrl) begin
      d.ctrl = pmsi_ctrl_t'(i_wb_dat[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      q <= ST_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  assign o_wb_dat = q.wb_dat;
  assign o_wb_ack = q.wb_ack;
  assign o_rxd = q.pins.d;
  assign o_rx_dv = q.pins.dv;
  assign o_crs = q.pins.crs;
  assign o_col = q.pins.col;
  assign o_crs_dv = q.pins.crs_dv;
  assign o_mac_clk = q.mac_clk;
  assign o_clk_out = q.clk_out;
  assign o_line_tx_valid = q.line_tx_vld;
  assign o_line_tx_data = q.line_tx_dat;
  assign o_line_tx_frame = q.line_tx_frm;
  assign o_adv_hi = q.adv.hi;
  assign o_adv_lo = q.adv.lo;
  assign o_resolved = q.res;
endmodule

// ==== design/pmsi_pkg.sv ====
/*
 * Shared constants, types and state records of the MAC-side interface.
 * Assumes a 125 MHz system clock; every rate below is derived from it.
 */
package pmsi_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MII_HZ = 2_500_000;
  localparam int unsigned LP_HZ = 5_000_000;
  localparam int unsigned RM_HZ = 50_000_000;
  localparam int unsigned FREE_HZ = 25_000_000;

  // Half period in system cycles, rounded down, never below one.
  function automatic logic [5:0] f_half(input int unsigned hz);
    int unsigned h;
    h = CLK_HZ / (2 * hz);
    if (h == 0) begin
      h = 1;
    end
    return h[5:0];
  endfunction

  localparam logic [5:0] HALF_MII = f_half(MII_HZ);
  localparam logic [5:0] HALF_LP = f_half(LP_HZ);
  localparam logic [5:0] HALF_RM = f_half(RM_HZ);
  localparam logic [5:0] HALF_FREE = f_half(FREE_HZ);

  localparam logic [2:0] MODE_MII = 3'h0;
  localparam logic [2:0] MODE_RMII_S = 3'h1;
  localparam logic [2:0] MODE_RMII_M = 3'h2;
  localparam logic [2:0] MODE_LP5 = 3'h3;
  localparam logic [2:0] MODE_RGMII = 3'h4;
  localparam logic [1:0] CKO_MAC = 2'h0;
  localparam logic [1:0] CKO_REF = 2'h1;
  localparam logic [1:0] CKO_FREE = 2'h2;
  localparam logic [1:0] CKO_REC = 2'h3;
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_LO = 2'h1;
  localparam logic [1:0] RES_HI = 2'h2;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_TXCNT = 8'h08;
  localparam logic [3:0] NIB_W = 4'h4;
  localparam logic [3:0] DIB_W = 4'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] NIB_LAST = 3'h1;
  localparam logic [2:0] DIB_LAST = 3'h3;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef struct packed {
    logic hdx;
    logic [1:0] cko;
    logic low_amp;
    logic rxdv_sel;
    logic [2:0] mode;
  } pmsi_ctrl_t;
  localparam int CTRL_W = $bits(pmsi_ctrl_t);
  localparam pmsi_ctrl_t CTRL_RST = 8'h00;

  typedef struct packed {logic lo; logic hi;} pmsi_abil_t;
  typedef struct packed {logic en; logic [3:0] d;} pmsi_mac_tx_t;
  typedef struct packed {
    logic dv; logic crs; logic col; logic crs_dv; logic [3:0] d;
  } pmsi_rx_pins_t;
  typedef struct packed {
    logic col; logic rx_act; logic tx_act; logic [1:0] res;
    pmsi_abil_t lp; pmsi_abil_t adv; logic strap_lo; logic strap_rxdv;
  } pmsi_stat_t;

  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_SHIFT = 2'b10} pmsi_rx_st_t;

  typedef struct packed {
    pmsi_ctrl_t ctrl;
    pmsi_mac_tx_t tx_s1; pmsi_mac_tx_t tx_s2;
    logic ref_s1; logic ref_s2; logic ref_d; logic rec_s1; logic rec_s2;
    logic [1:0] stp_s1; logic [1:0] stp_s2; logic [1:0] stp_wait;
    logic strap_rxdv; logic strap_lo;
    logic [7:0] tx_sh; logic [3:0] tx_bits;
    logic line_tx_vld; logic [7:0] line_tx_dat; logic line_tx_frm;
    logic [15:0] txcnt;
    pmsi_rx_st_t rx_st; logic [7:0] rx_sh; logic [2:0] rx_left;
    pmsi_rx_pins_t pins;
    logic mac_clk; logic clk_out;
    pmsi_abil_t lp; logic [1:0] res; pmsi_abil_t adv;
    logic wb_ack; logic [31:0] wb_dat;
  } pmsi_state_t;
  localparam pmsi_state_t ST_RST = '{ctrl: CTRL_RST, rx_st: RX_IDLE,
                                     adv: 2'h3, default: '0};

  typedef struct packed {logic [5:0] cnt; logic lvl; logic rise; logic fall;}
    pmsi_div_t;
  typedef struct packed {logic wp; logic rp; logic [1:0] cnt; logic rdy;}
    pmsi_fifo_t;
endpackage

// ==== tb/pmsi_mac_if_props.sv ====
/*
 * Port-level checker for pmsi_mac_if.
 * Assumes it is bound to every instance and sees only that module's ports.
 */
`timescale 1ns/1ps
module pmsi_mac_if_props (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Register bus.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  // MAC receive side and line transmit valid.
  input wire logic [3:0] o_rxd,
  input wire logic o_rx_dv,
  input wire logic o_crs,
  input wire logic o_col,
  input wire logic o_crs_dv,
  input wire logic o_line_tx_valid,
  // Abilities.
  input wire logic i_lp_valid,
  input wire pmsi_pkg::pmsi_abil_t i_lp_abil,
  input wire logic o_adv_lo,
  input wire logic [1:0] o_resolved
);
  import pmsi_pkg::*;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////
  sequence wb_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence ack_once;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  ack_pulse_a: assert property (wb_req |=> ack_once)
    else $error("ack not a single pulse one cycle after request");
  crs_rx_a: assert property (o_rx_dv |-> ##[0:1] o_crs)
    else $error("carrier low while receiving");
  col_crs_a: assert property (o_col |-> ##[0:1] o_crs)
    else $error("collision without carrier");
  dv_crs_a: assert property (o_crs_dv |-> ##[0:1] o_crs)
    else $error("combined valid without carrier");
  dv_keep_a: assert property (o_rx_dv |-> ##[0:1] o_crs_dv)
    else $error("combined pin low during valid data");
  adv_low_a: assert property (o_adv_lo)
    else $error("low level not advertised");
  res_low_a: assert property (i_lp_valid && i_lp_abil.lo &&
    !i_lp_abil.hi |-> ##[1:3] o_resolved == RES_LO)
    else $error("partner low only did not resolve low");
  res_none_a: assert property (i_lp_valid && !i_lp_abil.lo &&
    !i_lp_abil.hi |-> ##[1:3] o_resolved == RES_NONE)
    else $error("no common level did not resolve none");
  tx_pulse_a: assert property (o_line_tx_valid |=>
    !o_line_tx_valid [*3])
    else $error("byte valid too long or too close");
  rxd_idle_a: assert property (!o_rx_dv |-> o_rxd == 4'h0)
    else $error("receive data not zero while idle");
endmodule

bind pmsi_mac_if pmsi_mac_if_props u_props (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_rxd(o_rxd),
  .o_rx_dv(o_rx_dv), .o_crs(o_crs), .o_col(o_col), .o_crs_dv(o_crs_dv),
  .o_line_tx_valid(o_line_tx_valid), .i_lp_valid(i_lp_valid),
  .i_lp_abil(i_lp_abil), .o_adv_lo(o_adv_lo), .o_resolved(o_resolved)
);

// ==== tb/pmsi_mac_model.sv ====
/*
 * Behavioural MAC transmitter: sends one 16-bit word, low bits first.
 * Assumes its clock input is the interface clock it must follow.
 */
`timescale 1ns/1ps
module pmsi_mac_model (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Interface clock and symbol width.
  input wire logic i_mac_clk,
  input wire logic i_dibit,
  // Word to send.
  input wire logic i_go,
  input wire logic [15:0] i_word,
  // MAC pins.
  output logic o_tx_en,
  output logic [3:0] o_txd,
  output logic o_busy
);
  logic clk_q;
  logic [15:0] sh_q;
  logic [4:0] left_q;
  ////////////////////////////////////////////////////////////////////////
  // Symbols change on the falling edge, half a period clear of sampling.
  always @(posedge i_clk_sys) begin
    clk_q <= i_mac_clk;
    if (!i_rstn) begin
      left_q <= 5'h00;
      o_tx_en <= 1'b0;
      o_txd <= 4'h0;
    end else if (i_go && left_q == 5'h00) begin
      sh_q <= i_word;
      left_q <= 5'h10;
    end else if (clk_q && !i_mac_clk) begin
      if (left_q != 5'h00) begin
        o_tx_en <= 1'b1;
        o_txd <= i_dibit ? {2'h0, sh_q[1:0]} : sh_q[3:0];
        sh_q <= i_dibit ? sh_q >> 2 : sh_q >> 4;
        left_q <= left_q - (i_dibit ? 5'h02 : 5'h04);
      end else begin
        o_tx_en <= 1'b0;
        // Released pins do not keep the last symbol.
        o_txd <= ~o_txd;
      end
    end
  end
  assign o_busy = (left_q != 5'h00) || o_tx_en;
endmodule

// ==== tb/test_pmsi_mac_if.sv ====
/*
 * Self-checking bench for pmsi_mac_if.
 * Assumes the MAC model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
module test_pmsi_mac_if;
  import pmsi_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ref_ck = 1'b0;
  logic rec_ck = 1'b0;
  logic s_lo = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic lrx_v = 1'b0;
  logic [7:0] lrx_d = 8'h00;
  logic lcrs = 1'b0;
  logic lp_v = 1'b0;
  pmsi_abil_t lp_ab = 2'h0;
  logic go = 1'b0;
  logic [15:0] word = 16'h0;
  logic [2:0] mode = MODE_MII;
  logic [31:0] wb_q, rdat, cnt;
  logic ack, rdy, tx_v, frm, ahi, alo, rdv, crs, col, cdv, mclk, cko;
  logic ten, busy, mclk_q, cko_q, col_seen, crs_seen, full_seen, frm_seen;
  logic [3:0] rxd, txd;
  logic [7:0] tx_d;
  logic [1:0] res;
  logic [7:0] txq[$];
  logic [3:0] rxq[$];
  int mismatches = 0;
  int num_checks = 0;
  int cyc_n = 0;
  localparam logic [7:0] CV [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
                                    8'h20, 8'h40, 8'h02, 8'h60};
  localparam int EX [9] = '{12, 75, 300, 25, 12, 75, 150, 300, 60};
  always #4 clk = ~clk;
  always #32 ref_ck = ~ref_ck;
  always #40 rec_ck = ~rec_ck;
  ////////////////////////////////////////////////////////////////////////
  pmsi_mac_if i_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_ce(1'b1), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(4'hF), .o_wb_dat(wb_q), .o_wb_ack(ack),
    .i_ref_clock_input_pin(ref_ck), .i_rec_clk(rec_ck),
    .i_strap_rxdv(s_lo), .i_strap_low_amp(s_lo), .i_tx_en(ten),
    .i_txd(txd), .o_rxd(rxd), .o_rx_dv(rdv), .o_crs(crs), .o_col(col),
    .o_crs_dv(cdv), .o_mac_clk(mclk), .o_clk_out(cko),
    .i_line_rx_valid(lrx_v), .i_line_rx_data(lrx_d), .o_line_rx_ready(rdy),
    .i_line_crs(lcrs), .o_line_tx_valid(tx_v), .o_line_tx_data(tx_d),
    .o_line_tx_frame(frm), .i_lp_valid(lp_v), .i_lp_abil(lp_ab),
    .o_adv_hi(ahi), .o_adv_lo(alo), .o_resolved(res));
  pmsi_mac_model u_mac (
    .i_clk_sys(clk), .i_rstn(rstn),
    .i_mac_clk(mode == MODE_RMII_S ? ref_ck : mclk),
    .i_dibit(mode != MODE_MII && mode != MODE_RGMII), .i_go(go),
    .i_word(word), .o_tx_en(ten), .o_txd(txd), .o_busy(busy));
  always @(posedge clk) begin
    mclk_q <= mclk;
    cko_q <= cko;
    cyc_n <= cyc_n + 1;
    if (tx_v === 1'b1) txq.push_back(tx_d);
    if (mclk && !mclk_q && rdv === 1'b1) rxq.push_back(rxd);
    if (col === 1'b1) col_seen <= 1'b1;
    if (frm === 1'b1) frm_seen <= 1'b1;
    if (crs === 1'b1 && rdv === 1'b1) crs_seen <= 1'b1;
    if (rdy === 1'b0) full_seen <= 1'b1;
    if (cyc_n == 20000) begin
      mismatches++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = wb_q;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic do_reset(input logic s);
    rstn <= 1'b0;
    s_lo <= s;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    cnt = 32'h0;
  endtask
  task automatic send(input logic [15:0] w);
    txq.delete();
    frm_seen = 1'b0;
    word <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy === 1'b1);
    repeat (4) @(posedge clk);
    cnt = cnt + 32'h2;
  endtask
  task automatic t_regs();
    check({ahi, alo}, 2'h3);
    wb(1'b0, ADR_CTRL, 32'h0);
    check(rdat, 32'h0);
    wb(1'b0, 8'h0C, 32'h0);
    check(rdat, 32'h0);
    wb(1'b1, ADR_CTRL, 32'hFFFFFFFF);
    wb(1'b0, ADR_CTRL, 32'h0);
    check(rdat, 32'hFF);
    check(ahi, 1'b0);
    $display("registers done");
  endtask
  task automatic t_tx(input logic [2:0] m, input logic [15:0] w);
    mode <= m;
    wb(1'b1, ADR_CTRL, {29'h0, m});
    send(w);
    check(txq.size(), 2);
    check(txq[0], w[7:0]);
    check(txq[1], w[15:8]);
    wb(1'b0, ADR_TXCNT, 32'h0);
    check(rdat, cnt);
    check(frm_seen, 1'b1);
    $display("transmit mode %0d done", m);
  endtask
  task automatic t_rx();
    mode <= MODE_MII;
    wb(1'b1, ADR_CTRL, 32'h0);
    rxq.delete();
    full_seen = 1'b0;
    crs_seen = 1'b0;
    lrx_v <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      lrx_d <= 8'h5A ^ (8'h33 << i);
      do @(posedge clk); while (rdy !== 1'b1);
    end
    lrx_v <= 1'b0;
    repeat (400) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      check(rxq[i], ((8'h5A ^ (8'h33 << (i / 2))) >> (4 * (i % 2)))
            & 32'hF);
    end
    check(full_seen, 1'b1);
    check(crs_seen, 1'b1);
    $display("receive done");
  endtask
  task automatic t_col();
    for (int h = 0; h < 2; h++) begin
      wb(1'b1, ADR_CTRL, {24'h0, h[0], 7'h0});
      col_seen = 1'b0;
      lcrs <= 1'b1;
      send(16'h1234);
      lcrs <= 1'b0;
      check(col_seen, h[0]);
    end
    wb(1'b1, ADR_CTRL, 32'h8);
    lcrs <= 1'b1;
    repeat (4) @(posedge clk);
    check({crs, cdv}, 2'h2);
    wb(1'b1, ADR_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    check(cdv, 1'b1);
    lcrs <= 1'b0;
    $display("carrier done");
  endtask
  task automatic t_adv();
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, ADR_CTRL, {27'h0, k[2], 4'h0});
      lp_ab <= k[1:0];
      lp_v <= 1'b1;
      @(posedge clk);
      lp_v <= 1'b0;
      repeat (4) @(posedge clk);
      check(ahi, !k[2]);
      check(res, (!k[2] && k[0]) ? RES_HI : k[1] ? RES_LO : RES_NONE);
    end
    $display("abilities done");
  endtask
  task automatic t_clk();
    int n;
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, ADR_CTRL, {24'h0, CV[i]});
      repeat (60) @(posedge clk);
      n = 0;
      repeat (600) begin
        @(posedge clk);
        if (i < 5 ? (mclk && !mclk_q) : (cko && !cko_q)) n++;
      end
      n = (n >= EX[i] - 1 && n <= EX[i] + 1);
      check(n, 1);
    end
    $display("clocks done");
  endtask
  task automatic t_strap();
    do_reset(1'b1);
    wb(1'b0, ADR_STAT, 32'h0);
    check(rdat[1:0], 2'h3);
    check(ahi, 1'b0);
    lcrs <= 1'b1;
    repeat (4) @(posedge clk);
    check(cdv, 1'b0);
    lcrs <= 1'b0;
    do_reset(1'b0);
    check(ahi, 1'b1);
    $display("straps done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    t_regs();
    t_tx(MODE_MII, 16'hC35A);
    t_tx(MODE_RMII_S, 16'h96A5);
    t_tx(MODE_LP5, 16'h0FE1);
    t_tx(MODE_RGMII, 16'h3C0F);
    t_rx();
    t_col();
    t_adv();
    t_clk();
    t_strap();
    conclude();
  end
endmodule
